// ==== rtl/pgl_glue.sv ====
// Functional notes
// - decode 0xFFFA0000-0xFFFCFFFF, one 16-Kbyte window per peripheral
// - identifier is both interrupt index and clock-enable bit position
// - identifiers fixed: fast 0, system 1, io 2-4, ..., external 29-31
// - clock set/clear at locked positions changes no clock
// - converter clock starts by itself on first conversion request
// - in sleep mode converter clock stops after each conversion
// - source 1 is the OR of eight system unit interrupts
// - clocks of system interrupt units always run
// - identifier 1 has interrupt meaning only, no clock control
// - fast and external lines own identifiers, never clock gated
// - three io controllers of up to 32 lines each
// - each line is io or peripheral function a or b
// - io-reset line is pulled-up input, status bit reads 0
// - function-reset line driven by that function, status bit 1
// - function-reset lines also pulled up after reset
// - output-only functions may appear on several lines
`timescale 1ns/1ps
module pgl_glue
  import pgl_pkg::*;
#(
  parameter logic [31:0] IO_A_RESET_PSEL = pgl_pkg::RST_PSEL,
  parameter logic [31:0] IO_B_RESET_PSEL = pgl_pkg::RST_PSEL,
  parameter logic [31:0] IO_C_RESET_PSEL = pgl_pkg::RST_PSEL
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral window decode
  input wire logic [31:0] dec_addr,
  output logic dec_hit,
  output logic [pgl_pkg::PERIPH_SLOT_W-1:0] dec_slot,
  // interrupt sources
  input wire logic [31:0] periph_irq,
  input wire logic [pgl_pkg::NUM_SYS_SRC-1:0] sys_unit_irq,
  input wire logic fast_interrupt_line,
  input wire logic [pgl_pkg::NUM_EXT-1:0] ext_interrupt,
  output logic [31:0] irq_vec,
  output logic irq,
  // clock control
  output logic [31:0] periph_clk_en,
  output logic sys_unit_clk_en,
  // converter clock handling
  input wire logic adc_conv_req,
  input wire logic adc_conv_done,
  input wire logic adc_sleep,
  // io controllers a, b, c flattened by controller
  input wire logic [95:0] fa_out,
  input wire logic [95:0] fa_oe,
  input wire logic [95:0] fb_out,
  input wire logic [95:0] fb_oe,
  output logic [95:0] line_in,
  input wire logic [95:0] pad_in,
  output logic [95:0] pad_out,
  output logic [95:0] pad_oe,
  output logic [95:0] pad_pull
);

  import pgl_pkg::*;

  // window check and slot number from address
  function automatic logic in_window(input logic [31:0] a);
    in_window = (a >= PERIPH_BASE) && (a <= PERIPH_LAST);
  endfunction

  function automatic logic [PERIPH_SLOT_W-1:0] slot_of(input logic [31:0] a);
    logic [31:0] d;
    d = a - PERIPH_BASE;
    slot_of = d[PERIPH_WIN_BITS +: PERIPH_SLOT_W];
  endfunction

  logic [31:0] clk_en_q;
  logic adc_clk_q;
  logic [31:0] vec_q;
  logic [NUM_EVT-1:0] evt_sts_q;
  logic [NUM_EVT-1:0] evt_mask_q;
  logic dec_hit_q;
  logic [PERIPH_SLOT_W-1:0] dec_slot_q;
  logic dec_miss_ev;
  logic [3:0] x1_q, x2_q, x3_q, xl_q;
  logic [31:0] io_psel [NUM_IO_CTRL];
  logic [31:0] io_ab [NUM_IO_CTRL];
  logic [31:0] io_pull [NUM_IO_CTRL];
  logic [31:0] io_lvl [NUM_IO_CTRL];
  logic [NUM_IO_CTRL-1:0] io_wr;
  logic acc;
  logic wr;
  logic [7:0] off;
  logic io_range;
  logic [7:0] io_rel;
  logic [1:0] io_idx;
  logic [4:0] io_off;
  logic mapped;
  logic [31:0] rd_d;
  logic [31:0] locked_hit;
  logic sys_or;

  // zero-wait apb: every access completes in its first access cycle
  assign acc = psel & penable;
  assign wr = acc & pwrite & ce;
  assign off = paddr[7:0];
  assign io_range = (off >= OFF_IO_BASE) && (off < OFF_IO_END);
  assign io_rel = off - OFF_IO_BASE;
  assign io_idx = io_rel[6:5];
  assign io_off = io_rel[4:0];
  assign mapped = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'h0) &&
                  (io_range || off <= OFF_EVT_MASK);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign locked_hit = pwdata & CLK_LOCKED_MASK;

  // only gateable positions follow set and clear writes
  // position 1 stays out of the clock enables
  // fast and external positions never gain a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_q <= RST_CLK_EN;
    end else if (wr && mapped && off == OFF_CLK_SET) begin
      clk_en_q <= clk_en_q | (pwdata & ~CLK_LOCKED_MASK);
    end else if (wr && mapped && off == OFF_CLK_CLR) begin
      clk_en_q <= clk_en_q & ~(pwdata & ~CLK_LOCKED_MASK);
    end
  end

  // converter clock starts on a request
  // sleep mode stops it after the conversion ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_clk_q <= 1'b0;
    end else if (ce) begin
      if (adc_conv_req) begin
        adc_clk_q <= 1'b1;
      end else if (adc_conv_done && adc_sleep) begin
        adc_clk_q <= 1'b0;
      end
    end
  end

  // enables indexed by identifier, converter bit self-driven
  always_comb begin
    periph_clk_en = clk_en_q;
    periph_clk_en[ID_ADC] = adc_clk_q;
  end

  // system interrupt units run regardless of any setting
  assign sys_unit_clk_en = 1'b1;

  // external fast and interrupt pins pass three flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x1_q <= 4'h0;
      x2_q <= 4'h0;
      x3_q <= 4'h0;
      xl_q <= 4'h0;
    end else if (ce) begin
      x1_q <= {ext_interrupt, fast_interrupt_line};
      x2_q <= x1_q;
      x3_q <= x2_q;
      xl_q <= (x2_q & ~(x2_q ^ x3_q)) | (xl_q & (x2_q ^ x3_q));
    end
  end

  // source 1 ORs the eight system unit lines
  assign sys_or = |sys_unit_irq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_q <= 32'h0000_0000;
    end else if (ce) begin
      vec_q <= periph_irq & ~ID_RESERVED_MASK & ~CLK_LOCKED_MASK;
      vec_q[ID_ADC] <= periph_irq[ID_ADC];
      vec_q[ID_USB_HOST] <= periph_irq[ID_USB_HOST];
      vec_q[ID_FAST] <= xl_q[0];
      vec_q[ID_SYS] <= sys_or;
      vec_q[ID_EXT0 +: NUM_EXT] <= xl_q[3:1];
    end
  end
  assign irq_vec = vec_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_hit_q <= 1'b0;
      dec_slot_q <= '0;
    end else if (ce) begin
      dec_hit_q <= in_window(dec_addr);
      dec_slot_q <= in_window(dec_addr) ? slot_of(dec_addr) : '0;
    end
  end
  assign dec_hit = dec_hit_q;
  assign dec_slot = dec_slot_q;

  // a miss is an address in the top region outside the window
  assign dec_miss_ev = (dec_addr[31:28] == 4'hF) && !in_window(dec_addr);

  // sticky events, a new event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_sts_q <= '0;
    end else if (ce) begin
      evt_sts_q[EVT_ADC_DONE] <= adc_conv_done |
        (evt_sts_q[EVT_ADC_DONE] &
         ~(wr && mapped && off == OFF_EVT_STS && pwdata[EVT_ADC_DONE]));
      evt_sts_q[EVT_LOCKED_WR] <=
        (wr && mapped && (off == OFF_CLK_SET || off == OFF_CLK_CLR) &&
         |locked_hit) |
        (evt_sts_q[EVT_LOCKED_WR] &
         ~(wr && mapped && off == OFF_EVT_STS && pwdata[EVT_LOCKED_WR]));
      evt_sts_q[EVT_DEC_MISS] <= dec_miss_ev |
        (evt_sts_q[EVT_DEC_MISS] &
         ~(wr && mapped && off == OFF_EVT_STS && pwdata[EVT_DEC_MISS]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_q <= RST_EVT_MASK;
    end else if (wr && mapped && off == OFF_EVT_MASK) begin
      evt_mask_q <= pwdata[NUM_EVT-1:0];
    end
  end

  assign irq = |(evt_sts_q & evt_mask_q);

  // three io controllers of 32 lines
  localparam logic [95:0] IO_RESET_PSEL =
    {IO_C_RESET_PSEL, IO_B_RESET_PSEL, IO_A_RESET_PSEL};

  genvar k;
  generate
    for (k = 0; k < NUM_IO_CTRL; k++) begin : g_io
      assign io_wr[k] = wr && mapped && io_range && io_idx == 2'(k);
      pgl_io_ctrl #(
        .LINES(IO_LINES),
        .RESET_PSEL(IO_RESET_PSEL[k*32 +: 32]),
        .RESET_AB(RST_AB_SEL)
      ) u_io (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .wr_en(io_wr[k]),
        .wr_off(io_off),
        .wdata(pwdata),
        .psel_stat(io_psel[k]),
        .ab_stat(io_ab[k]),
        .pull_stat(io_pull[k]),
        .pin_lvl(io_lvl[k]),
        .fa_out(fa_out[k*32 +: 32]),
        .fa_oe(fa_oe[k*32 +: 32]),
        .fb_out(fb_out[k*32 +: 32]),
        .fb_oe(fb_oe[k*32 +: 32]),
        .line_in(line_in[k*32 +: 32]),
        .pad_in(pad_in[k*32 +: 32]),
        .pad_out(pad_out[k*32 +: 32]),
        .pad_oe(pad_oe[k*32 +: 32]),
        .pad_pull(pad_pull[k*32 +: 32])
      );
    end
  endgenerate

  // read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    if (io_range && io_idx < 2'(NUM_IO_CTRL)) begin
      unique case (io_off)
        IO_PSEL_STAT: rd_d = io_psel[io_idx];
        IO_AB_SEL: rd_d = io_ab[io_idx];
        IO_PULL_STAT: rd_d = io_pull[io_idx];
        IO_PIN_LVL: rd_d = io_lvl[io_idx];
        default: rd_d = 32'h0000_0000;
      endcase
    end else begin
      unique case (off)
        OFF_CLK_STAT: rd_d = periph_clk_en;
        OFF_IRQ_VEC: rd_d = vec_q;
        OFF_EVT_STS: rd_d = 32'(evt_sts_q);
        OFF_EVT_MASK: rd_d = 32'(evt_mask_q);
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // read data registered at setup so it is stable in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= mapped ? rd_d : 32'h0000_0000;
    end
  end

endmodule

// ==== rtl/pgl_pkg.sv ====
package pgl_pkg;

  // identifier assignment
  localparam int unsigned ID_FAST = 0;
  localparam int unsigned ID_SYS = 1;
  localparam int unsigned ID_IO_A = 2;
  localparam int unsigned ID_IO_B = 3;
  localparam int unsigned ID_IO_C = 4;
  localparam int unsigned ID_ADC = 5;
  localparam int unsigned ID_USART0 = 6;
  localparam int unsigned ID_USART1 = 7;
  localparam int unsigned ID_USART2 = 8;
  localparam int unsigned ID_CARD = 9;
  localparam int unsigned ID_USB_DEV = 10;
  localparam int unsigned ID_TWI0 = 11;
  localparam int unsigned ID_SPI0 = 12;
  localparam int unsigned ID_SPI1 = 13;
  localparam int unsigned ID_SYNC_SER = 14;
  localparam int unsigned ID_RSVD0 = 15;
  localparam int unsigned ID_RSVD1 = 16;
  localparam int unsigned ID_TC0 = 17;
  localparam int unsigned ID_USB_HOST = 20;
  localparam int unsigned ID_ETH = 21;
  localparam int unsigned ID_IMG = 22;
  localparam int unsigned ID_USART3 = 23;
  localparam int unsigned ID_TWI1 = 25;
  localparam int unsigned ID_TC3 = 26;
  localparam int unsigned ID_EXT0 = 29;

  localparam int unsigned NUM_ID = 32;
  localparam int unsigned NUM_SYS_SRC = 8;
  localparam int unsigned NUM_EXT = 3;
  localparam int unsigned NUM_IO_CTRL = 3;
  localparam int unsigned IO_LINES = 32;

  // bits whose clock cannot be set or cleared by software
  localparam logic [31:0] CLK_LOCKED_MASK = 32'hE011_8023;
  // positions with no peripheral behind them
  localparam logic [31:0] ID_RESERVED_MASK = 32'h0001_8000;

  // peripheral user interface window
  localparam logic [31:0] PERIPH_BASE = 32'hFFFA_0000;
  localparam logic [31:0] PERIPH_LAST = 32'hFFFC_FFFF;
  localparam int unsigned PERIPH_WIN_BITS = 14;
  localparam int unsigned PERIPH_SLOT_W = 4;

  // register offsets
  localparam logic [7:0] OFF_CLK_SET = 8'h00;
  localparam logic [7:0] OFF_CLK_CLR = 8'h04;
  localparam logic [7:0] OFF_CLK_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_VEC = 8'h0C;
  localparam logic [7:0] OFF_EVT_STS = 8'h10;
  localparam logic [7:0] OFF_EVT_MASK = 8'h14;
  localparam logic [7:0] OFF_IO_BASE = 8'h20;
  localparam logic [7:0] OFF_IO_STRIDE = 8'h20;
  localparam logic [7:0] OFF_IO_END = 8'h80;

  // offsets inside one io controller block
  localparam logic [4:0] IO_PERIPH_EN = 5'h00;
  localparam logic [4:0] IO_PERIPH_DIS = 5'h04;
  localparam logic [4:0] IO_PSEL_STAT = 5'h08;
  localparam logic [4:0] IO_AB_SEL = 5'h0C;
  localparam logic [4:0] IO_PULL_EN = 5'h10;
  localparam logic [4:0] IO_PULL_DIS = 5'h14;
  localparam logic [4:0] IO_PULL_STAT = 5'h18;
  localparam logic [4:0] IO_PIN_LVL = 5'h1C;

  // event status bit positions
  localparam int unsigned EVT_ADC_DONE = 0;
  localparam int unsigned EVT_LOCKED_WR = 1;
  localparam int unsigned EVT_DEC_MISS = 2;
  localparam int unsigned NUM_EVT = 3;

  // reset values
  localparam logic [31:0] RST_CLK_EN = 32'h0000_0000;
  localparam logic [31:0] RST_PSEL = 32'h0000_0000;
  localparam logic [31:0] RST_AB_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_PULL = 32'hFFFF_FFFF;
  localparam logic [2:0] RST_EVT_MASK = 3'h0;

endpackage

// ==== rtl/pgl_io_ctrl.sv ====
`timescale 1ns/1ps
module pgl_io_ctrl
  import pgl_pkg::*;
#(
  parameter int unsigned LINES = pgl_pkg::IO_LINES,
  parameter logic [31:0] RESET_PSEL = pgl_pkg::RST_PSEL,
  parameter logic [31:0] RESET_AB = pgl_pkg::RST_AB_SEL
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // register access
  input wire logic wr_en,
  input wire logic [4:0] wr_off,
  input wire logic [31:0] wdata,
  output logic [31:0] psel_stat,
  output logic [31:0] ab_stat,
  output logic [31:0] pull_stat,
  output logic [31:0] pin_lvl,
  // peripheral side
  input wire logic [LINES-1:0] fa_out,
  input wire logic [LINES-1:0] fa_oe,
  input wire logic [LINES-1:0] fb_out,
  input wire logic [LINES-1:0] fb_oe,
  output logic [LINES-1:0] line_in,
  // pads
  input wire logic [LINES-1:0] pad_in,
  output logic [LINES-1:0] pad_out,
  output logic [LINES-1:0] pad_oe,
  output logic [LINES-1:0] pad_pull
);

  import pgl_pkg::*;

  logic [LINES-1:0] psel_q;
  logic [LINES-1:0] ab_q;
  logic [LINES-1:0] pull_q;
  logic [LINES-1:0] s1_q, s2_q, s3_q, lvl_q;

  // reset as io input, status low, pulled up
  // reset-named lines come up in peripheral mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel_q <= RESET_PSEL[LINES-1:0];
    end else if (ce && wr_en && wr_off == IO_PERIPH_EN) begin
      psel_q <= psel_q | wdata[LINES-1:0];
    end else if (ce && wr_en && wr_off == IO_PERIPH_DIS) begin
      psel_q <= psel_q & ~wdata[LINES-1:0];
    end
  end

  // choice of function a or b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_q <= RESET_AB[LINES-1:0];
    end else if (ce && wr_en && wr_off == IO_AB_SEL) begin
      ab_q <= wdata[LINES-1:0];
    end
  end

  // pull-up on after reset for every line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_q <= RST_PULL[LINES-1:0];
    end else if (ce && wr_en && wr_off == IO_PULL_EN) begin
      pull_q <= pull_q | wdata[LINES-1:0];
    end else if (ce && wr_en && wr_off == IO_PULL_DIS) begin
      pull_q <= pull_q & ~wdata[LINES-1:0];
    end
  end

  // pad level synchroniser, accepted once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else if (ce) begin
      s1_q <= pad_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
    end
  end

  // pad mux, io mode leaves the line as input
  // same peripheral output may feed several lines
  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_line
      assign pad_out[i] = ab_q[i] ? fb_out[i] : fa_out[i];
      assign pad_oe[i] = psel_q[i] & (ab_q[i] ? fb_oe[i] : fa_oe[i]);
    end
  endgenerate

  assign pad_pull = pull_q;
  assign line_in = lvl_q;
  assign psel_stat = 32'(psel_q);
  assign ab_stat = 32'(ab_q);
  assign pull_stat = 32'(pull_q);
  assign pin_lvl = 32'(lvl_q);

endmodule

// ==== testbench/pgl_far_model.sv ====
`timescale 1ns/1ps
module pgl_far_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // glue side
  input wire logic [31:0] irq_vec,
  input wire logic [31:0] periph_clk_en,
  // controller view
  output logic any_pend,
  output logic [31:0] clk_seen_q
);
  logic [31:0] pend_q;

  // sources latch as pending until reset, like a level capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 32'h0;
    end else begin
      pend_q <= pend_q | irq_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_seen_q <= 32'h0;
    end else begin
      clk_seen_q <= clk_seen_q | periph_clk_en;
    end
  end

  assign any_pend = |pend_q;
endmodule

// ==== testbench/pgl_glue_monitor.sv ====
`timescale 1ns/1ps
module pgl_glue_monitor
  import pgl_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // decode
  input wire logic [31:0] dec_addr,
  input wire logic dec_hit,
  input wire logic [pgl_pkg::PERIPH_SLOT_W-1:0] dec_slot,
  // interrupts and clocks
  input wire logic [31:0] periph_irq,
  input wire logic [pgl_pkg::NUM_SYS_SRC-1:0] sys_unit_irq,
  input wire logic fast_interrupt_line,
  input wire logic [31:0] irq_vec,
  input wire logic [31:0] periph_clk_en,
  input wire logic sys_unit_clk_en,
  input wire logic adc_conv_req,
  input wire logic adc_conv_done,
  input wire logic adc_sleep,
  // pads
  input wire logic [95:0] pad_oe,
  input wire logic [95:0] pad_pull
);
  logic [31:0] off;
  logic in_win;
  assign off = dec_addr - PERIPH_BASE;
  assign in_win = dec_addr >= PERIPH_BASE && dec_addr <= PERIPH_LAST;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dec_window: assert property (
    ce && in_win |=> dec_hit && dec_slot == $past(off[17:14]))
    else $error("decode hit or slot wrong");
  a_dec_miss: assert property (
    ce && !in_win |=> !dec_hit && dec_slot == 4'h0)
    else $error("decode hit outside window");
  a_sys_or: assert property (
    ce |=> irq_vec[1] == $past(|sys_unit_irq))
    else $error("system source not or of units");
  a_vec_map: assert property (
    ce |=> irq_vec[28:17] == $past(periph_irq[28:17])
      && irq_vec[14:2] == $past(periph_irq[14:2]))
    else $error("vector not indexed by identifier");
  a_fixed_zero: assert property (
    (periph_clk_en & 32'hE011_8003) == 32'h0 && irq_vec[16:15] == 2'h0)
    else $error("locked clock or reserved bit set");
  a_adc_start: assert property (
    ce && adc_conv_req |=> periph_clk_en[5])
    else $error("converter clock did not start");
  a_adc_stop: assert property (
    ce && adc_conv_done && adc_sleep && !adc_conv_req |=> !periph_clk_en[5])
    else $error("converter clock did not stop");
  a_sys_clk_on: assert property (sys_unit_clk_en)
    else $error("system unit clock gated");
  a_fast_sync: assert property (
    (ce && fast_interrupt_line) [*6] |-> irq_vec[0])
    else $error("fast line not in vector");
  a_pull_reset: assert property (
    $rose(presetn) |-> &pad_pull && pad_oe == 96'h0)
    else $error("pad reset state wrong");
endmodule

bind pgl_glue pgl_glue_monitor i_pgl_glue_monitor (.pclk, .presetn, .ce,
  .dec_addr, .dec_hit, .dec_slot, .periph_irq, .sys_unit_irq,
  .fast_interrupt_line, .irq_vec, .periph_clk_en, .sys_unit_clk_en,
  .adc_conv_req, .adc_conv_done, .adc_sleep, .pad_oe, .pad_pull);

// ==== testbench/pgl_glue_test.sv ====
`timescale 1ns/1ps
module pgl_glue_test;
  import pgl_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, dec_addr, periph_irq, irq_vec;
  logic [31:0] periph_clk_en, v, r, clk_q;
  logic [3:0] dec_slot;
  logic [7:0] sys_unit_irq;
  logic [2:0] ext_interrupt;
  logic dec_hit, fast_interrupt_line, irq, sys_unit_clk_en, er, any_pend;
  logic adc_conv_req, adc_conv_done, adc_sleep;
  logic [95:0] fa_out, fa_oe, fb_out, fb_oe, line_in, pad_in, pad_out;
  logic [95:0] pad_oe, pad_pull;
  int n_mismatch, checked, i;
  logic [31:0] edge_a [3] = '{32'hFFF9_FFFF, 32'hFFFC_FFFF, 32'hFFFD_0000};

  pgl_glue #(.IO_C_RESET_PSEL(32'h0000_00F0)) i_pgl_glue (.pclk, .presetn,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dec_addr, .dec_hit, .dec_slot, .periph_irq, .sys_unit_irq,
    .fast_interrupt_line, .ext_interrupt, .irq_vec, .irq, .periph_clk_en,
    .sys_unit_clk_en, .adc_conv_req, .adc_conv_done, .adc_sleep, .fa_out,
    .fa_oe, .fb_out, .fb_oe, .line_in, .pad_in, .pad_out, .pad_oe,
    .pad_pull);
  pgl_far_model i_pgl_far_model (.pclk, .presetn, .irq_vec,
    .periph_clk_en, .any_pend, .clk_seen_q(clk_q));

  always #50 pclk = ~pclk;

  function automatic logic [31:0] exp_vec(input logic [31:0] p);
    return p & 32'h1FFE_7FFC;
  endfunction
  function automatic logic [31:0] exp_clk(input logic [31:0] c, s, k);
    return (c | s) & ~k & 32'h1FEE_7FDC;
  endfunction

  task automatic chk_word(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk_word($sformatf("read %h", a), e, r);
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // stop a hang well past the expected run length
  initial begin
    #1_000_000;
    n_mismatch++;
    final_report;
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {periph_irq, sys_unit_irq, fast_interrupt_line, ext_interrupt} = '0;
    {adc_conv_req, adc_conv_done, adc_sleep, fa_oe, fb_oe} = '0;
    {fa_out, fb_out, pad_in} = '0;
    n_mismatch = 0;
    checked = 0;
    ce = 1'b1;
    dec_addr = 32'h0;
    v = $urandom(32'h8d5f6b75);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    step(1);
    rd(32'h28, 32'h0);
    rd(32'h68, 32'h0000_00F0);
    rd(32'h78, 32'hFFFF_FFFF);
    apb(1'b0, 32'h18, 32'h0);
    chk_bit("unmapped error", 1'b1, er);
    for (i = 0; i < 15; i++) begin
      v = i < 12 ? PERIPH_BASE + (i << 14) + ($urandom % 16384) : edge_a[i-12];
      @(posedge pclk) dec_addr <= v;
      step(1);
      chk_bit("hit", i < 12 || i == 13, dec_hit);
      chk_word("slot", i < 12 ? i : (i == 13 ? 11 : 0), dec_slot);
    end
    @(posedge pclk) dec_addr <= 32'h0;
    for (i = 0; i < 8; i++) begin
      v = $urandom;
      @(posedge pclk) periph_irq <= v;
      sys_unit_irq <= 8'h1 << i;
      step(2);
      chk_word("vector", exp_vec(v) | 32'h2, irq_vec);
    end
    rd(32'h0C, exp_vec(v) | 32'h2);
    @(posedge pclk) sys_unit_irq <= 8'h0;
    fast_interrupt_line <= 1'b1;
    ext_interrupt <= 3'b101;
    step(8);
    chk_word("ext", 32'hA000_0001, irq_vec & 32'hE000_0003);
    chk_bit("far", 1'b1, any_pend);
    apb(1'b1, 32'h00, 32'hFFFF_FFFF);
    step(1);
    chk_word("clk", 32'h1FEE_7FDC, periph_clk_en);
    chk_bit("sysclk", 1'b1, sys_unit_clk_en);
    rd(32'h08, 32'h1FEE_7FDC);
    v = $urandom;
    apb(1'b1, 32'h04, v);
    step(1);
    chk_word("clk", exp_clk(32'h1FEE_7FDC, 0, v), periph_clk_en);
    @(posedge pclk) ce <= 1'b0;
    apb(1'b1, 32'h00, 32'hFFFF_FFFF);
    @(posedge pclk) ce <= 1'b1;
    step(1);
    chk_word("frozen", exp_clk(32'h1FEE_7FDC, 0, v), periph_clk_en);
    @(posedge pclk) adc_conv_req <= 1'b1;
    @(posedge pclk) adc_conv_req <= 1'b0;
    #1 chk_bit("adc on", 1'b1, periph_clk_en[5]);
    @(posedge pclk) adc_conv_done <= 1'b1;
    @(posedge pclk) adc_conv_done <= 1'b0;
    #1 chk_bit("adc awake", 1'b1, periph_clk_en[5]);
    @(posedge pclk) adc_conv_done <= 1'b1;
    adc_sleep <= 1'b1;
    @(posedge pclk) adc_conv_done <= 1'b0;
    #1 chk_bit("adc off", 1'b0, periph_clk_en[5]);
    for (i = 0; i < 3; i++) begin
      chk_bit("irq masked", 1'b0, irq);
      apb(1'b1, 32'h14, 32'h1 << i);
      step(1);
      chk_bit("irq", 1'b1, irq);
      apb(1'b1, 32'h10, 32'h1 << i);
      step(1);
      chk_bit("irq cleared", 1'b0, irq);
    end
    // lines 0 and 2 carry the same output-only function a
    @(posedge pclk) {fa_out, fa_oe} <= {{3{32'h5}}, {3{32'h5}}};
    {fb_out, fb_oe} <= {{3{32'h2}}, {3{32'h2}}};
    for (i = 0; i < 3; i++) begin
      apb(1'b1, 32'h20 + 32 * i, 32'h7);
      apb(1'b1, 32'h2C + 32 * i, 32'h2);
      rd(32'h28 + 32 * i, i == 2 ? 32'hF7 : 32'h7);
      step(1);
      chk_word("oe", 32'h7, pad_oe[i*32 +: 32] & 32'hF);
      chk_word("out", 32'h7, pad_out[i*32 +: 32] & 32'h7);
      apb(1'b1, 32'h24 + 32 * i, 32'h7);
      v = $urandom;
      @(posedge pclk) pad_in[i*32 +: 32] <= v;
      step(6);
      chk_word("oe io", 32'h0, pad_oe[i*32 +: 32] & 32'hF);
      chk_word("line in", v, line_in[i*32 +: 32]);
      @(posedge pclk) pad_in[i*32 +: 32] <= ~v;
      step(6);
      chk_word("line fall", ~v, line_in[i*32 +: 32]);
      rd(32'h3C + 32 * i, ~v);
      apb(1'b1, 32'h34 + 32 * i, v);
      rd(32'h38 + 32 * i, ~v);
      chk_word("pull", ~v, pad_pull[i*32 +: 32]);
    end
    chk_word("far clk", 32'h1FEE_7FFC, clk_q);
    final_report;
  end
endmodule
